// File: hw/pcs_cfg_bank.sv
// Behaviour
// - bit 31 of dword 0Ch always reads one: self test supported.
// - writing one to start_self_test (bit 30) launches the queue memory test.
// - start_self_test stays set while testing, clears itself when finished.
// - bit 26 reports an interrupt queue memory fault after the test.
// - bit 25 reports a transmit queue memory fault after the test.
// - bit 24 reports a receive queue memory fault after the test.
// - header type bits 23:16 always read 80h.
// - latency timer bits 15:11 writable, bits 10:8 read zero.
// - master releases bus after latency count once grant is removed.
// - claim memory cycles matching base bits 31:20 when nonzero and enabled.
// - unimplemented window locations read zero, writes have no effect.
// - base bits 19:4 read zero and ignore writes: 1 MB aligned window.
// - base bit 3 reads zero: not prefetchable.
// - base bits 2:1 read zero: anywhere in 32-bit space.
// - base bit 0 reads zero: memory space base.
// - memory space enable gates the window decode.
`timescale 1ns/10ps
module pcs_cfg_bank
  import pcs_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  // configuration access
  input  wire logic        cfg_rd_in,
  input  wire logic        cfg_wr_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic      [31:0] cfg_rdata_out,
  // command register link
  input  wire logic        mem_space_en_in,
  // memory cycle decode
  input  wire logic        mem_cycle_in,
  input  wire logic        mem_write_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic        mem_impl_in,
  input  wire logic [31:0] mem_local_rdata_in,
  output logic             mem_claim_out,
  output logic             mem_local_we_out,
  output logic      [31:0] mem_rdata_out,
  // bus master tenure
  input  wire logic        master_frame_start_in,
  input  wire logic        master_gnt_in,
  output logic             master_release_out,
  // self test status
  output logic             self_test_busy_out
);
  pcs_state_e                  state_r;
  pcs_state_e                  state_nxt;
  logic                        start_r;
  logic                        start_nxt;
  logic [PCS_NUM_QUEUES-1:0]   err_r;
  logic [PCS_NUM_QUEUES-1:0]   err_nxt;
  logic [PCS_Q_AW-1:0]         addr_r;
  logic [PCS_Q_AW-1:0]         addr_nxt;
  logic                        pass_r;
  logic                        pass_nxt;
  logic [PCS_LAT_W-1:0]        lat_r;
  logic [PCS_LAT_W-1:0]        lat_nxt;
  logic [PCS_BASE_W-1:0]       base_r;
  logic [PCS_BASE_W-1:0]       base_nxt;
  logic [31:0]                 rdata_nxt;
  logic                        claim_nxt;
  logic                        we_nxt;
  logic [31:0]                 mrdata_nxt;
  logic                        ram_we;
  logic [PCS_Q_DW-1:0]         pattern;
  logic [PCS_Q_DW-1:0]         ram_rdata [0:PCS_NUM_QUEUES-1];
  logic                        wr_dw3;
  logic                        wr_dw4;
  logic                        hit;

  assign wr_dw3  = cfg_wr_in && (cfg_addr_in == PCS_OFF_SELFTEST_HDR_LAT);
  assign wr_dw4  = cfg_wr_in && (cfg_addr_in == PCS_OFF_MEM_WINDOW_BASE);
  assign pattern = (pass_r ? PCS_PAT_B : PCS_PAT_A) ^ {{(PCS_Q_DW-PCS_Q_AW){1'b0}}, addr_r};
  assign ram_we  = (state_r == PCS_ST_WR);

  // queue memories under test: 0 receive, 1 transmit, 2 interrupt
  genvar g;
  generate
    for (g = 0; g < PCS_NUM_QUEUES; g++) begin : g_queue
      pcs_queue_ram u_ram (
        .clock_in  (clock_in),
        .we_in     (ram_we),
        .addr_in   (addr_r),
        .wdata_in  (pattern),
        .rdata_out (ram_rdata[g])
      );
    end
  endgenerate

  // self test sequencer
  always_comb begin
    state_nxt = state_r;
    start_nxt = start_r;
    err_nxt   = err_r;
    addr_nxt  = addr_r;
    pass_nxt  = pass_r;
    case (state_r)
      PCS_ST_IDLE: begin
        if (wr_dw3 && cfg_be_in[3] && cfg_wdata_in[PCS_BIT_START]) begin
          start_nxt = 1'b1;
          err_nxt   = '0;
          addr_nxt  = '0;
          pass_nxt  = 1'b0;
          state_nxt = PCS_ST_WR;
        end
      end
      PCS_ST_WR: begin
        addr_nxt = addr_r + 4'h1;
        if (addr_r == {PCS_Q_AW{1'b1}}) begin
          state_nxt = PCS_ST_RD;
        end
      end
      PCS_ST_RD: begin
        state_nxt = PCS_ST_CMP;
      end
      PCS_ST_CMP: begin
        for (int i = 0; i < PCS_NUM_QUEUES; i++) begin
          if (ram_rdata[i] != pattern) begin
            err_nxt[i] = 1'b1;
          end
        end
        addr_nxt = addr_r + 4'h1;
        if (addr_r != {PCS_Q_AW{1'b1}}) begin
          state_nxt = PCS_ST_RD;
        end else if (!pass_r) begin
          pass_nxt  = 1'b1;
          state_nxt = PCS_ST_WR;
        end else begin
          state_nxt = PCS_ST_DONE;
        end
      end
      PCS_ST_DONE: begin
        start_nxt = 1'b0;
        state_nxt = PCS_ST_IDLE;
      end
      default: begin
        state_nxt = PCS_ST_IDLE;
        start_nxt = 1'b0;
      end
    endcase
  end

  // writable fields
  always_comb begin
    lat_nxt  = lat_r;
    base_nxt = base_r;
    if (wr_dw3 && cfg_be_in[1]) begin
      lat_nxt = cfg_wdata_in[PCS_LAT_LSB +: PCS_LAT_W];
    end
    if (wr_dw4 && cfg_be_in[3]) begin
      base_nxt[11:4] = cfg_wdata_in[31:24];
    end
    if (wr_dw4 && cfg_be_in[2]) begin
      base_nxt[3:0] = cfg_wdata_in[23:20];
    end
  end

  // configuration read data
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (cfg_rd_in && (cfg_addr_in == PCS_OFF_SELFTEST_HDR_LAT)) begin
      rdata_nxt[PCS_BIT_CAPABLE]                 = 1'b1;
      rdata_nxt[PCS_BIT_START]                   = start_r;
      rdata_nxt[PCS_BIT_ERR_INTQ]                = err_r[2];
      rdata_nxt[PCS_BIT_ERR_TXQ]                 = err_r[1];
      rdata_nxt[PCS_BIT_ERR_RXQ]                 = err_r[0];
      rdata_nxt[PCS_HDR_LSB +: 8]                = PCS_HEADER_TYPE;
      rdata_nxt[PCS_LAT_LSB +: PCS_LAT_W]        = lat_r;
    end else if (cfg_rd_in && (cfg_addr_in == PCS_OFF_MEM_WINDOW_BASE)) begin
      rdata_nxt[PCS_BASE_LSB +: PCS_BASE_W]      = base_r;
    end
  end

  // memory window decode
  assign hit = mem_cycle_in && mem_space_en_in && (base_r != '0)
               && (mem_addr_in[31:20] == base_r);

  always_comb begin
    claim_nxt  = hit;
    we_nxt     = hit && mem_write_in && mem_impl_in;
    mrdata_nxt = 32'h00000000;
    if (hit && !mem_write_in && mem_impl_in) begin
      mrdata_nxt = mem_local_rdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r            <= PCS_ST_IDLE;
      start_r            <= 1'b0;
      err_r              <= '0;
      addr_r             <= '0;
      pass_r             <= 1'b0;
      lat_r              <= PCS_LAT_RESET;
      base_r             <= PCS_BASE_RESET;
      cfg_rdata_out      <= 32'h00000000;
      mem_claim_out      <= 1'b0;
      mem_local_we_out   <= 1'b0;
      mem_rdata_out      <= 32'h00000000;
      self_test_busy_out <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      start_r            <= start_nxt;
      err_r              <= err_nxt;
      addr_r             <= addr_nxt;
      pass_r             <= pass_nxt;
      lat_r              <= lat_nxt;
      base_r             <= base_nxt;
      cfg_rdata_out      <= rdata_nxt;
      mem_claim_out      <= claim_nxt;
      mem_local_we_out   <= we_nxt;
      mem_rdata_out      <= mrdata_nxt;
      self_test_busy_out <= start_nxt;
    end
  end

  // bus tenure limit
  pcs_latency_timer u_lat (
    .clock_in       (clock_in),
    .resetn_in      (resetn_in),
    .frame_start_in (master_frame_start_in),
    .gnt_in         (master_gnt_in),
    .lat_value_in   ({lat_r, 3'b000}),
    .release_out    (master_release_out)
  );
endmodule : pcs_cfg_bank

// File: hw/pcs_latency_timer.sv
`timescale 1ns/10ps
module pcs_latency_timer
  import pcs_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  // master tenure
  input  wire logic       frame_start_in,
  input  wire logic       gnt_in,
  input  wire logic [7:0] lat_value_in,
  output logic            release_out
);
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       active_r;
  logic       active_nxt;
  logic       release_nxt;

  // counts clocks from frame start, releases once expired and grant gone
  always_comb begin
    count_nxt   = count_r;
    active_nxt  = active_r;
    release_nxt = 1'b0;
    if (frame_start_in) begin
      count_nxt  = lat_value_in;
      active_nxt = 1'b1;
    end else if (active_r) begin
      if (count_r != 8'h00) begin
        count_nxt = count_r - 8'h01;
      end else if (!gnt_in) begin
        release_nxt = 1'b1;
        active_nxt  = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_r     <= 8'h00;
      active_r    <= 1'b0;
      release_out <= 1'b0;
    end else begin
      count_r     <= count_nxt;
      active_r    <= active_nxt;
      release_out <= release_nxt;
    end
  end
endmodule : pcs_latency_timer

// File: hw/pcs_pkg.sv
package pcs_pkg;
  // configuration dword offsets
  localparam logic [7:0]  PCS_OFF_SELFTEST_HDR_LAT = 8'h0c;
  localparam logic [7:0]  PCS_OFF_MEM_WINDOW_BASE  = 8'h10;
  // selftest_header_latency fields
  localparam int          PCS_BIT_CAPABLE          = 31;
  localparam int          PCS_BIT_START            = 30;
  localparam int          PCS_BIT_ERR_INTQ         = 26;
  localparam int          PCS_BIT_ERR_TXQ          = 25;
  localparam int          PCS_BIT_ERR_RXQ          = 24;
  localparam int          PCS_HDR_LSB              = 16;
  localparam logic [7:0]  PCS_HEADER_TYPE          = 8'h80;
  localparam int          PCS_LAT_LSB              = 11;
  localparam int          PCS_LAT_W                = 5;
  localparam logic [4:0]  PCS_LAT_RESET            = 5'h00;
  // memory_window_base fields
  localparam int          PCS_BASE_LSB             = 20;
  localparam int          PCS_BASE_W               = 12;
  localparam logic [11:0] PCS_BASE_RESET           = 12'h000;
  // self test memories
  localparam int          PCS_NUM_QUEUES           = 3;
  localparam int          PCS_Q_AW                 = 4;
  localparam int          PCS_Q_DW                 = 32;
  localparam logic [31:0] PCS_PAT_A                = 32'h5555aaaa;
  localparam logic [31:0] PCS_PAT_B                = 32'haaaa5555;
  // host-side limit for self test completion
  localparam int          PCS_SELFTEST_LIMIT_S     = 2;

  typedef enum logic [4:0] {
    PCS_ST_IDLE = 5'b00001,
    PCS_ST_WR   = 5'b00010,
    PCS_ST_RD   = 5'b00100,
    PCS_ST_CMP  = 5'b01000,
    PCS_ST_DONE = 5'b10000
  } pcs_state_e;
endpackage : pcs_pkg

// File: hw/pcs_queue_ram.sv
`timescale 1ns/10ps
module pcs_queue_ram
  import pcs_pkg::*;
(
  // clock
  input  wire logic                clock_in,
  // access
  input  wire logic                we_in,
  input  wire logic [PCS_Q_AW-1:0] addr_in,
  input  wire logic [PCS_Q_DW-1:0] wdata_in,
  output logic      [PCS_Q_DW-1:0] rdata_out
);
  logic [PCS_Q_DW-1:0] mem_r [0:(1<<PCS_Q_AW)-1];

  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_r[addr_in] <= wdata_in;
    end
    rdata_out <= mem_r[addr_in];
  end
endmodule : pcs_queue_ram

// File: verification/pcs_cfg_bank_asserts.sv
`timescale 1ns/10ps
module pcs_cfg_bank_asserts
  import pcs_pkg::*;
(
  // watched ports
  input wire logic        clock_in,
  input wire logic        resetn_in,
  input wire logic        cfg_rd_in,
  input wire logic        cfg_wr_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [3:0]  cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        mem_space_en_in,
  input wire logic        mem_cycle_in,
  input wire logic        mem_write_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic        mem_impl_in,
  input wire logic        mem_claim_out,
  input wire logic        mem_local_we_out,
  input wire logic [31:0] mem_rdata_out,
  input wire logic        master_gnt_in,
  input wire logic        master_release_out,
  input wire logic        self_test_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_cap_bit_one: assert property ($past(cfg_rd_in) && $past(cfg_addr_in) == 8'h0c |-> cfg_rdata_out[31])
    else $error("capability bit low");
  a_hdr_type_const: assert property ($past(cfg_rd_in) && $past(cfg_addr_in) == 8'h0c |-> cfg_rdata_out[23:16] == 8'h80)
    else $error("header type wrong");
  a_resv_bits_zero: assert property ($past(cfg_rd_in) && $past(cfg_addr_in) == 8'h0c |-> cfg_rdata_out[29:27] == 3'h0 && cfg_rdata_out[10:0] == 11'h0)
    else $error("reserved bits set");
  a_base_low_zero: assert property ($past(cfg_rd_in) && $past(cfg_addr_in) == 8'h10 |-> cfg_rdata_out[19:0] == 20'h0)
    else $error("base low bits set");
  a_start_launch: assert property (cfg_wr_in && cfg_addr_in == 8'h0c && cfg_be_in[3] && cfg_wdata_in[30] |-> ##[1:2] self_test_busy_out)
    else $error("self test not launched");
  a_test_ends: assert property ($rose(self_test_busy_out) |-> ##[1:150] !self_test_busy_out)
    else $error("self test never ends");
  a_claim_cause: assert property (mem_claim_out |-> $past(mem_cycle_in) && $past(mem_space_en_in) && $past(mem_addr_in[31:20]) != 12'h0)
    else $error("claim without cause");
  a_no_claim_off: assert property (mem_cycle_in && !mem_space_en_in |=> !mem_claim_out)
    else $error("claim while disabled");
  a_unimpl_quiet: assert property (mem_claim_out && !$past(mem_impl_in) |-> mem_rdata_out == 32'h0 && !mem_local_we_out)
    else $error("unimplemented location active");
  a_we_on_write: assert property (mem_local_we_out |-> mem_claim_out && $past(mem_write_in))
    else $error("stray write strobe");
  a_release_nogrant: assert property (master_release_out |-> !$past(master_gnt_in))
    else $error("release while granted");
  a_start_busy_match: assert property ($past(cfg_rd_in) && $past(cfg_addr_in) == 8'h0c |-> cfg_rdata_out[30] == $past(self_test_busy_out))
    else $error("start bit disagrees with busy");
  a_rdata_idle_zero: assert property (!$past(cfg_rd_in) |-> cfg_rdata_out == 32'h0)
    else $error("read data without read");
endmodule : pcs_cfg_bank_asserts
bind pcs_cfg_bank pcs_cfg_bank_asserts chk_i (.*);

// File: verification/pcs_host_model.sv
`timescale 1ns/10ps
module pcs_host_model
  import pcs_pkg::*;
(
  // clock and answers
  input  wire logic        clock_in,
  input  wire logic [31:0] cfg_rdata_in,
  input  wire logic        mem_claim_in,
  input  wire logic        mem_we_in,
  input  wire logic [31:0] mem_rdata_in,
  // requests
  output logic             cfg_rd_out,
  output logic             cfg_wr_out,
  output logic      [7:0]  cfg_addr_out,
  output logic      [3:0]  cfg_be_out,
  output logic      [31:0] cfg_wdata_out,
  output logic             mem_cycle_out,
  output logic             mem_write_out,
  output logic      [31:0] mem_addr_out
);
  // scaled-down stand-in for the two second give-up time
  localparam int POLL_LIMIT = 300;
  initial begin
    {cfg_rd_out, cfg_wr_out, mem_cycle_out, mem_write_out} = 4'h0;
    {cfg_addr_out, cfg_be_out, cfg_wdata_out, mem_addr_out} = '0;
  end
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge clock_in);
    {cfg_rd_out, cfg_wr_out, cfg_addr_out, cfg_be_out, cfg_wdata_out} = {!w, w, a, be, d};
    @(negedge clock_in);
    q = cfg_rdata_in;
    {cfg_rd_out, cfg_wr_out, cfg_addr_out, cfg_wdata_out} = {2'b00, ~a, ~d};
  endtask : cfg
  task automatic mem(input logic w, input logic [31:0] a, output logic c,
                     output logic we, output logic [31:0] q);
    @(negedge clock_in);
    {mem_cycle_out, mem_write_out, mem_addr_out} = {1'b1, w, a};
    @(negedge clock_in);
    {c, we, q} = {mem_claim_in, mem_we_in, mem_rdata_in};
    {mem_cycle_out, mem_addr_out} = {1'b0, ~a};
  endtask : mem
  // poll start bit, give up after the limit
  task automatic poll(output int n);
    logic [31:0] q;
    n = 0;
    do begin
      cfg(1'b0, 8'h0c, 4'h0, 32'h0, q);
      n++;
    end while (q[30] && n < POLL_LIMIT);
  endtask : poll
endmodule : pcs_host_model

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  import pcs_pkg::*;
  logic        clock_in = 0, resetn_in = 0, mem_space_en_in = 0, mem_impl_in = 0;
  logic        master_frame_start_in = 0, master_gnt_in = 0, start = 0, c, w, we;
  logic        cfg_rd_in, cfg_wr_in, mem_cycle_in, mem_write_in, hit;
  logic        mem_claim_out, mem_local_we_out, master_release_out, self_test_busy_out;
  logic [7:0]  cfg_addr_in;
  logic [3:0]  cfg_be_in;
  logic [4:0]  lat = 0;
  logic [11:0] base = 0;
  logic [31:0] cfg_wdata_in, mem_addr_in, cfg_rdata_out, mem_rdata_out, d, q, a;
  logic [31:0] mem_local_rdata_in = 0;
  int          miscompares = 0, samples_checked = 0, seed = 18002, i, n;
  always #5 clock_in = ~clock_in;
  pcs_cfg_bank pcs_cfg_bank_i (.*);
  pcs_host_model pcs_host_model_i (.clock_in, .cfg_rdata_in(cfg_rdata_out),
    .mem_claim_in(mem_claim_out), .mem_we_in(mem_local_we_out), .mem_rdata_in(mem_rdata_out),
    .cfg_rd_out(cfg_rd_in), .cfg_wr_out(cfg_wr_in), .cfg_addr_out(cfg_addr_in),
    .cfg_be_out(cfg_be_in), .cfg_wdata_out(cfg_wdata_in), .mem_cycle_out(mem_cycle_in),
    .mem_write_out(mem_write_in), .mem_addr_out(mem_addr_in));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  function automatic logic [31:0] exp0c();
    return {1'b1, start, 6'h0, 8'h80, lat, 11'h0};
  endfunction : exp0c
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    pcs_host_model_i.cfg(1'b0, ad, 4'h0, 32'h0, q);
    chk("cfg read", e, q);
  endtask : rd
  task automatic wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] v);
    pcs_host_model_i.cfg(1'b1, ad, be, v, q);
    if (ad == 8'h0c && be[1]) lat = v[15:11];
    if (ad == 8'h0c && be[3] && v[30]) start = 1;
    if (ad == 8'h10 && be[3]) base[11:4] = v[31:24];
    if (ad == 8'h10 && be[2]) base[3:0] = v[23:20];
  endtask : wr
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge clock_in);
    resetn_in = 1;
    rd(8'h0c, exp0c());
    rd(8'h10, 32'h0);
    wr(8'h14, 4'hf, 32'hffffffff);
    rd(8'h14, 32'h0);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      d = $random(seed) & 32'hbfffffff;
      wr(8'h0c, d[7:4], d);
      rd(8'h0c, exp0c());
      d = $random(seed);
      wr(8'h10, d[3:0], d);
      rd(8'h10, {base, 20'h0});
    end
    wr(8'h10, 4'hc, $random(seed) | 32'h80000000);
    rd(8'h10, {base, 20'h0});
    $display("test fields done");
    mem_space_en_in = 1;
    for (i = 0; i < 16; i++) begin
      a = $random(seed);
      if (i[0]) a[31:20] = base;
      if (i == 12) mem_space_en_in = 0;
      mem_impl_in = a[3];
      mem_local_rdata_in = $random(seed);
      w = a[2];
      hit = mem_space_en_in && a[31:20] == base;
      pcs_host_model_i.mem(w, a, c, we, d);
      chk("claim", hit, c);
      chk("write strobe", hit && mem_impl_in && w, we);
      if (!w) chk("window data", (hit && mem_impl_in) ? mem_local_rdata_in : 0, d);
    end
    $display("test window done");
    wr(8'h0c, 4'h8, 32'h40000000);
    rd(8'h0c, exp0c());
    chk("busy running", start, self_test_busy_out);
    wr(8'h0c, 4'hf, {16'h0, lat, 11'h0});
    rd(8'h0c, exp0c());
    pcs_host_model_i.poll(n);
    start = 0;
    chk("self test ended", 1, n < 300);
    chk("busy ended", start, self_test_busy_out);
    rd(8'h0c, exp0c());
    $display("test self test done");
    for (i = 0; i < 4; i++) begin
      wr(8'h0c, 4'h2, i << 11);
      master_frame_start_in = 1;
      @(negedge clock_in);
      master_frame_start_in = 0;
      for (n = 1; n < 60 && !master_release_out; n++) @(negedge clock_in);
      chk("release delay", i * 8 + 2, n);
    end
    wr(8'h0c, 4'h2, 32'h00000800);
    master_gnt_in = 1;
    master_frame_start_in = 1;
    @(negedge clock_in);
    master_frame_start_in = 0;
    for (n = 0; n < 20 && !master_release_out; n++) @(negedge clock_in);
    chk("release held", 20, n);
    master_gnt_in = 0;
    for (n = 1; n < 60 && !master_release_out; n++) @(negedge clock_in);
    chk("release on drop", 2, n);
    $display("test latency done");
    resetn_in = 0;
    {lat, base, start} = '0;
    repeat (2) @(negedge clock_in);
    resetn_in = 1;
    rd(8'h0c, exp0c());
    rd(8'h10, 32'h0);
    chk("busy after reset", start, self_test_busy_out);
    $display("test second reset done");
    final_report();
  end
endmodule : testbench
